// file: common/ddp_map.svh
/*
 Constants of the double-rate memory datapath: group widths, counts, reset values.
 Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef DDP_MAP_SVH
`define DDP_MAP_SVH
`define DDP_DQ_W         36
`define DDP_GRP_W        4
`define DDP_ADDR_W       16
`define DDP_CMD_W        4
`define DDP_FIFO_DEPTH   32
`define DDP_FIFO_AW      5
`define DDP_MODE_X8      3'h0
`define DDP_MODE_X9      3'h1
`define DDP_MODE_X16     3'h2
`define DDP_MODE_X18     3'h3
`define DDP_MODE_X32     3'h4
`define DDP_MODE_X36     3'h5
`define DDP_MEM_DDR      1'h0
`define DDP_MEM_QDR      1'h1
`define DDP_BL_TWO       2'h0
`define DDP_RST_CMD      4'hF
`endif

// file: common/ddp_pkg.sv
/*
 Types of the double-rate memory datapath.
 Assumes ddp_map.svh on the include path.
*/
`include "ddp_map.svh"
package ddp_pkg;
    // Write beat: both halves plus mask, loaded together
    typedef struct packed {
        logic [`DDP_DQ_W-1:0]  high;
        logic [`DDP_DQ_W-1:0]  low;
        logic [`DDP_GRP_W-1:0] mask_high;
        logic [`DDP_GRP_W-1:0] mask_low;
    } ddp_wbeat_s;
    // Read beat: rising and falling capture of one cycle
    typedef struct packed {
        logic [`DDP_DQ_W-1:0] high;
        logic [`DDP_DQ_W-1:0] low;
    } ddp_rbeat_s;
    // Address and command, single rate
    typedef struct packed {
        logic [`DDP_ADDR_W-1:0] addr;
        logic [`DDP_CMD_W-1:0]  cmd;
    } ddp_ac_s;
    typedef enum logic [1:0] {
        DDP_IDLE  = 2'h0,
        DDP_PRE   = 2'h1,
        DDP_WRITE = 2'h2
    } ddp_wr_e;
endpackage

// file: rtl/ddp_fifo.sv
/*
 Synchronous FIFO with valid/ready on both sides.
 Assumes one clock; width and depth are structural parameters.
*/
`timescale 1ns/10ps
module ddp_fifo #(
    parameter int WIDTH = 72,
    parameter int DEPTH = 32,
    parameter int AW    = 5
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr_r;
    logic [AW:0]      rd_ptr_r;
    wire              push;
    wire              pop;
    wire              full;
    wire              empty;

    // Extra pointer bit tells full from empty
    assign full      = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
    assign empty     = (wr_ptr_r == rd_ptr_r);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign push      = in_valid && !full;
    assign pop       = out_ready && !empty;
    assign out_data  = mem[rd_ptr_r[AW-1:0]];

    // Storage has no reset; only pointers matter
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_r[AW-1:0]] <= in_data;
        end
    end

    // Pointer update
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            wr_ptr_r <= wr_ptr_r + (AW+1)'(push);
            rd_ptr_r <= rd_ptr_r + (AW+1)'(pop);
        end
    end
endmodule

// file: rtl/ddp_phy.sv
/*
 Double-rate memory datapath: read capture, sync and FIFO, write output cells,
 strobe preamble, memory clock, single-rate address and command.
 Assumes capture and write clocks come from a PLL outside; phase tuning is done there.
 The capture clock is sampled by sys_clk as a plain input.
*/
`timescale 1ns/10ps
`include "ddp_map.svh"
module ddp_phy (
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    input  wire logic                   wr_clk,
    input  wire logic                   cap_clk,
    input  wire logic [2:0]             width_mode,
    input  wire logic                   mem_type,
    input  wire logic [1:0]             burst_len,
    input  wire ddp_pkg::ddp_ac_s       ac_in,
    input  wire logic                   ac_valid,
    input  wire ddp_pkg::ddp_wbeat_s    wr_beat,
    input  wire logic                   wr_valid,
    output logic                        wr_ready,
    output logic                        cfg_refused,
    output ddp_pkg::ddp_rbeat_s         rd_beat,
    output logic                        rd_valid,
    input  wire logic                   rd_ready,
    input  wire logic                   rd_en,
    output logic                        rd_overflow,
    output ddp_pkg::ddp_ac_s            ac_out,
    output logic                        mem_clk,
    output logic                        mem_clk_n,
    input  wire logic [`DDP_DQ_W-1:0]   dq_in,
    output logic [`DDP_DQ_W-1:0]        dq_out,
    output logic [`DDP_DQ_W-1:0]        dq_oe_n,
    output logic [`DDP_GRP_W-1:0]       dm_out,
    output logic [`DDP_GRP_W-1:0]       dm_oe_n,
    output logic [`DDP_GRP_W-1:0]       dqs_out,
    output logic [`DDP_GRP_W-1:0]       dqs_oe_n,
    input  wire logic [`DDP_GRP_W-1:0]  dqs_in
);
    // Active pin mask per width mode; extra pins stay plain I/O when narrow
    function automatic logic [`DDP_DQ_W-1:0] lane_mask(input logic [2:0] m);
        unique case (m)
            `DDP_MODE_X8:  lane_mask = 36'h0000000FF;
            `DDP_MODE_X9:  lane_mask = 36'h0000001FF;
            `DDP_MODE_X16: lane_mask = 36'h00000FFFF;
            `DDP_MODE_X18: lane_mask = 36'h00003FFFF;
            `DDP_MODE_X32: lane_mask = 36'h0FFFFFFFF;
            `DDP_MODE_X36: lane_mask = 36'hFFFFFFFFF;
            default:       lane_mask = 36'h0000000FF;
        endcase
    endfunction

    // Strobe groups in use: one mask and strobe per group
    function automatic logic [`DDP_GRP_W-1:0] grp_mask(input logic [2:0] m);
        unique case (m)
            `DDP_MODE_X8, `DDP_MODE_X9:   grp_mask = 4'h1;
            `DDP_MODE_X16, `DDP_MODE_X18: grp_mask = 4'h3;
            `DDP_MODE_X32, `DDP_MODE_X36: grp_mask = 4'hF;
            default:                      grp_mask = 4'h1;
        endcase
    endfunction

    // Returned strobe deliberately unused during reads
    wire [`DDP_GRP_W-1:0] strobe_unused = dqs_in;

    wire [`DDP_DQ_W-1:0]  lanes = lane_mask(width_mode);
    wire [`DDP_GRP_W-1:0] grps  = grp_mask(width_mode);
    // QDR II at burst length two is not offered
    wire refuse = (mem_type == `DDP_MEM_QDR) && (burst_len == `DDP_BL_TWO);
    // Mask pins only exist for DDR-type writes
    wire dm_used = (mem_type == `DDP_MEM_DDR);

    // Capture clock sampled into sys_clk domain, edges found after two flops
    logic [2:0] cap_sync_r;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cap_sync_r <= 3'h0;
        end else begin
            cap_sync_r <= {cap_sync_r[1:0], cap_clk};
        end
    end
    wire cap_rise = cap_sync_r[1] && !cap_sync_r[2];
    wire cap_fall = !cap_sync_r[1] && cap_sync_r[2];

    // Pin data through two flops before any use
    logic [`DDP_DQ_W-1:0] dq_meta_r;
    logic [`DDP_DQ_W-1:0] dq_s_r;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            dq_meta_r <= '0;
            dq_s_r    <= '0;
        end else begin
            dq_meta_r <= dq_in;
            dq_s_r    <= dq_meta_r;
        end
    end

    // Three capture registers per pin, PLL capture clock not the strobe
    logic [`DDP_DQ_W-1:0] rise_capture_reg;
    logic [`DDP_DQ_W-1:0] fall_capture_reg;
    logic [`DDP_DQ_W-1:0] fall_realign_reg;
    logic                 cap_pair_r;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rise_capture_reg <= '0;
            fall_capture_reg <= '0;
            fall_realign_reg <= '0;
            cap_pair_r       <= 1'h0;
        end else begin
            if (cap_rise) begin
                rise_capture_reg <= dq_s_r & lanes;
                fall_realign_reg <= fall_capture_reg;
            end
            if (cap_fall) begin
                fall_capture_reg <= dq_s_r & lanes;
            end
            cap_pair_r <= cap_rise && rd_en;
        end
    end

    // Sync pair ahead of the FIFO
    logic [`DDP_DQ_W-1:0] sync_high_r;
    logic [`DDP_DQ_W-1:0] sync_low_r;
    logic                 sync_valid_r;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sync_high_r  <= '0;
            sync_low_r   <= '0;
            sync_valid_r <= 1'h0;
        end else begin
            sync_high_r  <= rise_capture_reg;
            sync_low_r   <= fall_realign_reg;
            sync_valid_r <= cap_pair_r;
        end
    end

    // FIFO aligns both streams; a full FIFO drops the beat and flags it
    wire                 fifo_in_ready;
    ddp_pkg::ddp_rbeat_s fifo_in;
    ddp_pkg::ddp_rbeat_s fifo_out;
    wire                 fifo_out_valid;
    wire                 rd_take;
    assign fifo_in.high = sync_high_r;
    assign fifo_in.low  = sync_low_r;
    ddp_fifo #(
        .WIDTH (2*`DDP_DQ_W),
        .DEPTH (`DDP_FIFO_DEPTH),
        .AW    (`DDP_FIFO_AW)
    ) u_rd_fifo (
        .clk       (sys_clk),
        .rst       (rst),
        .in_data   (fifo_in),
        .in_valid  (sync_valid_r),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out),
        .out_valid (fifo_out_valid),
        .out_ready (rd_take)
    );

    // Registered output stage: take a word when empty or being drained
    assign rd_take = fifo_out_valid && (!rd_valid || rd_ready);
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rd_beat     <= '0;
            rd_valid    <= 1'h0;
            rd_overflow <= 1'h0;
        end else begin
            if (rd_take) begin
                rd_beat <= fifo_out;
            end
            rd_valid    <= rd_take || (rd_valid && !rd_ready);
            rd_overflow <= rd_overflow || (sync_valid_r && !fifo_in_ready);
        end
    end

    // Write sequencer: preamble cycle before the first beat
    ddp_pkg::ddp_wr_e wr_state_r;
    ddp_pkg::ddp_wr_e wr_state_nxt;
    always_comb begin
        wr_state_nxt = wr_state_r;
        unique case (wr_state_r)
            ddp_pkg::DDP_IDLE:  if (wr_valid && !refuse) wr_state_nxt = ddp_pkg::DDP_PRE;
            ddp_pkg::DDP_PRE:   wr_state_nxt = ddp_pkg::DDP_WRITE;
            ddp_pkg::DDP_WRITE: if (!wr_valid) wr_state_nxt = ddp_pkg::DDP_IDLE;
            default:            wr_state_nxt = ddp_pkg::DDP_IDLE;
        endcase
    end
    wire beat_take = (wr_state_r == ddp_pkg::DDP_WRITE) && wr_valid;

    // System-clock launch: sequencer, strobe enables, single-rate command
    logic                 dqs_oe_r;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wr_state_r  <= ddp_pkg::DDP_IDLE;
            wr_ready    <= 1'h0;
            cfg_refused <= 1'h0;
            dqs_oe_r    <= 1'h0;
            ac_out      <= {`DDP_ADDR_W'h0, `DDP_RST_CMD};
        end else begin
            wr_state_r  <= wr_state_nxt;
            wr_ready    <= (wr_state_nxt == ddp_pkg::DDP_WRITE);
            cfg_refused <= refuse;
            dqs_oe_r    <= (wr_state_nxt != ddp_pkg::DDP_IDLE);
            if (ac_valid) begin
                ac_out <= ac_in;
            end
        end
    end

    // Second active-low enable adds half a cycle of high impedance
    always_ff @(negedge sys_clk or posedge rst) begin
        if (rst) begin
            dqs_oe_n <= 4'hF;
        end else begin
            dqs_oe_n <= ~(grps & {`DDP_GRP_W{dqs_oe_r}});
        end
    end

    // Strobe held high on the used groups one cycle behind the write state; it does not toggle like memory clock
    logic strobe_en_r;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            strobe_en_r <= 1'h0;
        end else begin
            strobe_en_r <= (wr_state_nxt == ddp_pkg::DDP_WRITE);
        end
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            dqs_out <= 4'h0;
        end else begin
            dqs_out <= grps & {`DDP_GRP_W{strobe_en_r}};
        end
    end
    // Memory clock through a double-rate cell: high half loads one, low half zero
    logic clk_high_r;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            clk_high_r <= 1'h0;
        end else begin
            clk_high_r <= 1'h1;
        end
    end
    // Clock level picks the half; pair stays parked while reset holds
    assign mem_clk   = sys_clk ? clk_high_r : 1'h0;
    assign mem_clk_n = sys_clk ? ~clk_high_r : 1'h1;

    // Write data cells on the lagging write clock: both streams load together
    logic [`DDP_DQ_W-1:0]  out_low_reg;
    logic [`DDP_DQ_W-1:0]  out_high_reg;
    logic [`DDP_GRP_W-1:0] dm_low_r;
    logic [`DDP_GRP_W-1:0] dm_high_r;
    logic                  data_oe_r;
    always_ff @(posedge wr_clk or posedge rst) begin
        if (rst) begin
            out_low_reg  <= '0;
            out_high_reg <= '0;
            dm_low_r     <= 4'hF;
            dm_high_r    <= 4'hF;
            data_oe_r    <= 1'h0;
        end else begin
            out_low_reg  <= wr_beat.low & lanes;
            out_high_reg <= wr_beat.high & lanes;
            dm_low_r     <= wr_beat.mask_low | ~grps;
            dm_high_r    <= wr_beat.mask_high | ~grps;
            data_oe_r    <= beat_take;
        end
    end

    // Low stream retimed on falling edge
    logic [`DDP_DQ_W-1:0]  low_retime_r;
    logic [`DDP_GRP_W-1:0] dm_low_retime_r;
    always_ff @(negedge wr_clk or posedge rst) begin
        if (rst) begin
            low_retime_r    <= '0;
            dm_low_retime_r <= 4'hF;
        end else begin
            low_retime_r    <= out_low_reg;
            dm_low_retime_r <= dm_low_r;
        end
    end

    // Clock level selects half; pin changes twice per cycle
    always_comb begin
        dq_out = wr_clk ? out_high_reg : low_retime_r;
        dm_out = wr_clk ? dm_high_r : dm_low_retime_r;
    end
    always_ff @(posedge wr_clk or posedge rst) begin
        if (rst) begin
            dq_oe_n <= '1;
            dm_oe_n <= 4'hF;
        end else begin
            dq_oe_n <= ~(lanes & {`DDP_DQ_W{data_oe_r}});
            dm_oe_n <= ~(grps & {`DDP_GRP_W{data_oe_r && dm_used}});
        end
    end
endmodule

// file: sim/ddp_mem_model.sv
/*
 Behavioural memory device on the far side of the datapath pins.
 Assumes the bench says when a read burst is on the wires.
*/
`timescale 1ns/10ps
`include "ddp_map.svh"
module ddp_mem_model (
    input  wire logic [`DDP_DQ_W-1:0]  rise_val,
    input  wire logic [`DDP_DQ_W-1:0]  fall_val,
    input  wire logic                  cap_clk,
    input  wire logic                  reading,
    input  wire logic                  mem_clk,
    input  wire ddp_pkg::ddp_ac_s      ac_out,
    input  wire logic [`DDP_DQ_W-1:0]  dq_out,
    input  wire logic [`DDP_DQ_W-1:0]  dq_oe_n,
    input  wire logic [`DDP_GRP_W-1:0] dqs_out,
    input  wire logic [`DDP_GRP_W-1:0] dqs_oe_n,
    output logic [`DDP_DQ_W-1:0]       dq_in,
    output logic [`DDP_GRP_W-1:0]      dqs_in
);
    logic [`DDP_DQ_W-1:0]  mem_dq = 36'h0_0000_0000;
    logic [`DDP_GRP_W-1:0] mem_dqs = 4'h0;
    ddp_pkg::ddp_ac_s      ac_seen;
    // Burst data per clock half; idle lines flip so stale values never pass
    always @(cap_clk or reading) begin
        if (reading) begin
            mem_dq = cap_clk ? rise_val : fall_val;
            mem_dqs = {4{~cap_clk}}; // Strobe skewed on purpose: capture must not use it
        end else begin
            mem_dq = ~mem_dq;
            mem_dqs = ~mem_dqs;
        end
    end
    // Address and command taken on the rising edge of mem_clk
    always @(posedge mem_clk) begin
        ac_seen <= ac_out;
    end
    // Wire level from whichever side has its driver on
    assign dq_in = (dq_out & ~dq_oe_n) | (mem_dq & dq_oe_n);
    assign dqs_in = (dqs_out & ~dqs_oe_n) | (mem_dqs & dqs_oe_n);
endmodule

// file: sim/ddp_phy_assertions.sv
/*
 Port-level checks of the double-rate datapath, bound into ddp_phy.
 Assumes a single sys_clk domain with asynchronous high reset.
*/
`timescale 1ns/10ps
`include "ddp_map.svh"
module ddp_phy_assertions (
    input wire logic                  sys_clk,
    input wire logic                  rst,
    input wire ddp_pkg::ddp_ac_s      ac_in,
    input wire logic                  ac_valid,
    input wire logic                  wr_valid,
    input wire logic                  wr_ready,
    input wire logic                  cfg_refused,
    input wire ddp_pkg::ddp_rbeat_s   rd_beat,
    input wire logic                  rd_valid,
    input wire logic                  rd_ready,
    input wire logic                  rd_overflow,
    input wire ddp_pkg::ddp_ac_s      ac_out,
    input wire logic                  mem_clk,
    input wire logic                  mem_clk_n,
    input wire logic [`DDP_DQ_W-1:0]  dq_oe_n,
    input wire logic [`DDP_GRP_W-1:0] dm_oe_n,
    input wire logic [`DDP_GRP_W-1:0] dqs_oe_n
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic seen_wr_r;
    // Remembers the first accepted write; pins stay released before it
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            seen_wr_r <= 1'b0;
        end else if (wr_valid && !cfg_refused) begin
            seen_wr_r <= 1'b1;
        end
    end
    // Pin, refusal and handshake relations
    property p_clk_pair; mem_clk_n == ~mem_clk; endproperty
    a_clk_pair: assert property (p_clk_pair) else $error("memory clock pair broken");
    property p_refuse; cfg_refused |-> !wr_ready; endproperty
    a_refuse: assert property (p_refuse) else $error("write granted in refused mode");
    property p_ac; ac_valid |=> ac_out == $past(ac_in); endproperty
    a_ac: assert property (p_ac) else $error("address not latched");
    property p_ac_hold; !ac_valid |=> $stable(ac_out); endproperty
    a_ac_hold: assert property (p_ac_hold) else $error("address moved without request");
    property p_hiz; !seen_wr_r |-> &dq_oe_n && &dm_oe_n && &dqs_oe_n; endproperty
    a_hiz: assert property (p_hiz) else $error("pin driven before first write");
    property p_pre; $rose(wr_valid) && !cfg_refused |-> &dqs_oe_n; endproperty
    a_pre: assert property (p_pre) else $error("strobe driven without preamble");
    property p_ready; $rose(wr_valid) && !cfg_refused |-> ##[2:3] wr_ready; endproperty
    a_ready: assert property (p_ready) else $error("write not granted in time");
    property p_stand; rd_valid && !rd_ready |=> rd_valid && $stable(rd_beat); endproperty
    a_stand: assert property (p_stand) else $error("read beat lost while stalled");
    property p_ovf; rd_overflow |=> rd_overflow; endproperty
    a_ovf: assert property (p_ovf) else $error("overflow flag cleared");
    c_write: cover property ($rose(wr_ready));
    c_ovf: cover property ($rose(rd_overflow));
    c_refuse: cover property (cfg_refused && wr_valid);
endmodule
bind ddp_phy ddp_phy_assertions u_chk (.sys_clk, .rst, .ac_in, .ac_valid, .wr_valid,
    .wr_ready, .cfg_refused, .rd_beat, .rd_valid, .rd_ready, .rd_overflow, .ac_out,
    .mem_clk, .mem_clk_n, .dq_oe_n, .dm_oe_n, .dqs_oe_n);

// file: sim/ddp_phy_tb_top.sv
/*
 Self-checking bench of ddp_phy: reset, refusal, address path, capture per mode,
 overflow and write cells. Assumes design, checker and memory model compiled first.
*/
`timescale 1ns/10ps
`include "ddp_map.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; \
    $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module ddp_phy_tb_top;
    logic                  sys_clk = 1'b0, rst = 1'b1, wr_clk = 1'b0, cap_clk = 1'b0;
    logic                  mem_type = 1'b0, ac_valid = 1'b0, wr_valid = 1'b0, reading = 1'b0;
    logic                  rd_ready = 1'b1, rd_en = 1'b0, wr_ready, cfg_refused, rd_valid;
    logic                  rd_overflow, mem_clk, mem_clk_n;
    logic [2:0]            width_mode = 3'h5;
    logic [1:0]            burst_len = 2'h1;
    ddp_pkg::ddp_ac_s      ac_in = 20'h0_0000, ac_out;
    ddp_pkg::ddp_wbeat_s   wr_beat = '0;
    ddp_pkg::ddp_rbeat_s   rd_beat;
    logic [`DDP_DQ_W-1:0]  dq_in, dq_out, dq_oe_n;
    logic [`DDP_DQ_W-1:0]  rise_val = 36'h9_A5C3_1E7F, fall_val = 36'h6_5A3C_E180;
    logic [`DDP_GRP_W-1:0] dm_out, dm_oe_n, dqs_out, dqs_oe_n, dqs_in;
    int                    fail_count = 0, checked = 0;
    int                    widths [6] = '{8, 9, 16, 18, 32, 36};
    // System clock; write clock trails it by a quarter period
    initial begin
        forever #2 sys_clk = ~sys_clk;
    end
    always @(sys_clk) wr_clk <= #1 sys_clk;
    // Capture clock runs free like a PLL output, phase unrelated
    initial begin
        #1.3;
        forever #16 cap_clk = ~cap_clk;
    end
    ddp_phy ddp_phy_inst (.sys_clk, .rst, .wr_clk, .cap_clk, .width_mode, .mem_type,
        .burst_len, .ac_in, .ac_valid, .wr_beat, .wr_valid, .wr_ready, .cfg_refused,
        .rd_beat, .rd_valid, .rd_ready, .rd_en, .rd_overflow, .ac_out, .mem_clk,
        .mem_clk_n, .dq_in, .dq_out, .dq_oe_n, .dm_out, .dm_oe_n, .dqs_out, .dqs_oe_n,
        .dqs_in);
    ddp_mem_model ddp_mem_model_inst (.rise_val, .fall_val, .cap_clk, .reading, .mem_clk,
        .ac_out, .dq_out, .dq_oe_n, .dqs_out, .dqs_oe_n, .dq_in, .dqs_in);
    // Inputs move half a ns after the rising edge, ahead of the write clock edge
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #0.5;
    endtask
    task automatic final_report();
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // A bounded wait that ran out ends the run
    task automatic expect_seen(input logic v);
        if (v !== 1'b1) begin
            fail_count++;
            $display("BAD t=%0t got=%0h exp=1", $time, v);
            final_report();
        end
    endtask
    task automatic t_cfg();
        for (int i = 0; i < 8; i++) begin
            mem_type = i[2];
            burst_len = i[1:0];
            tick(2);
            `CHK(cfg_refused, i[2] & (i[1:0] == 2'h0))
        end
        mem_type = `DDP_MEM_QDR;
        burst_len = `DDP_BL_TWO;
        tick(2);
        wr_valid = 1'b1;
        tick(6);
        `CHK(wr_ready, 1'b0)
        `CHK(dqs_oe_n, 4'hF)
        wr_valid = 1'b0;
        mem_type = `DDP_MEM_DDR;
        burst_len = 2'h1;
        tick(3);
        $display("burst refusal test done");
    endtask
    task automatic t_ac();
        ddp_pkg::ddp_ac_s v;
        for (int i = 0; i < 4; i++) begin
            v = {16'hA5C0 + 16'(i), 4'(i)};
            ac_in = v;
            ac_valid = 1'b1;
            tick(1);
            `CHK(ac_out, v)
        end
        ac_valid = 1'b0;
        ac_in = ~v;
        tick(3);
        `CHK(ac_out, v)
        `CHK(ddp_mem_model_inst.ac_seen, v)
        $display("address path test done");
    endtask
    // Unused lanes of narrow modes read back as zero
    task automatic t_read(input logic [2:0] mode, input int w);
        logic [`DDP_DQ_W-1:0] m;
        int n;
        m = (36'h1 << w) - 36'h1;
        width_mode = mode;
        reading = 1'b1;
        rd_en = 1'b1;
        n = 0;
        while (rd_valid !== 1'b1 && n < 80) begin
            tick(1);
            n++;
        end
        expect_seen(rd_valid);
        tick(24);
        `CHK(rd_beat.high, rise_val & m)
        `CHK(rd_beat.low, fall_val & m)
        `CHK(rd_beat.low & ~m, 36'h0_0000_0000)
        rd_en = 1'b0;
        reading = 1'b0;
        tick(48);
        `CHK(rd_valid, 1'b0)
        $display("read test done, width %0d", w);
    endtask
    // Reader stalls until the FIFO refuses, then drains it
    task automatic t_ovf();
        int n;
        width_mode = `DDP_MODE_X36;
        rd_ready = 1'b0;
        reading = 1'b1;
        rd_en = 1'b1;
        n = 0;
        while (rd_overflow !== 1'b1 && n < 600) begin
            tick(1);
            n++;
        end
        expect_seen(rd_overflow);
        rd_en = 1'b0;
        reading = 1'b0;
        tick(40);
        `CHK(rd_valid, 1'b1)
        rd_ready = 1'b1;
        n = 0;
        repeat (80) begin
            if (rd_valid === 1'b1) begin
                n++;
                `CHK(rd_beat.high, rise_val)
            end
            tick(1);
        end
        `CHK(n >= `DDP_FIFO_DEPTH, 1'b1)
        `CHK(rd_overflow, 1'b1)
        $display("overflow test done");
    endtask
    // High half while the write clock is high, low half while low
    task automatic check_pins(input ddp_pkg::ddp_wbeat_s b);
        @(posedge wr_clk);
        #0.5;
        `CHK(dq_out, b.high)
        `CHK(dm_out, b.mask_high)
        @(negedge wr_clk);
        #0.5;
        `CHK(dq_out, b.low)
        `CHK(dm_out, b.mask_low)
        `CHK(dq_oe_n, 36'h0_0000_0000)
        `CHK(dqs_out, 4'hF)
        tick(1);
    endtask
    task automatic t_write();
        ddp_pkg::ddp_wbeat_s b;
        int n;
        b = {36'hC_3A50_F1E2, 36'h3_C5AF_0E1D, 4'h5, 4'hA};
        wr_beat = b;
        wr_valid = 1'b1;
        #0.25;
        n = 0;
        while (dqs_oe_n[0] !== 1'b0 && n < 40) begin
            #0.5;
            n++;
        end
        expect_seen(~dqs_oe_n[0]);
        `CHK(sys_clk, 1'b0)
        tick(1);
        expect_seen(wr_ready);
        tick(4);
        check_pins(b);
        b = {~b.high, ~b.low, 4'h3, 4'hC};
        wr_beat = b;
        tick(4);
        check_pins(b);
        `CHK(dm_oe_n, 4'h0)
        wr_valid = 1'b0;
        tick(8);
        $display("write test done");
    endtask
    initial begin
        tick(4);
        rst = 1'b0;
        tick(1);
        `CHK(dq_oe_n, 36'hF_FFFF_FFFF)
        `CHK(dm_oe_n & dqs_oe_n, 4'hF)
        `CHK(ac_out.cmd, `DDP_RST_CMD)
        `CHK(rd_valid, 1'b0)
        $display("reset test done");
        t_cfg();
        t_ac();
        for (int i = 0; i < 6; i++) begin
            t_read(3'(i), widths[i]);
        end
        t_ovf();
        // Mid-run reset clears the sticky overflow and releases every pin
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        tick(1);
        `CHK(rd_overflow, 1'b0)
        `CHK(dq_oe_n, 36'hF_FFFF_FFFF)
        `CHK(dm_oe_n & dqs_oe_n, 4'hF)
        $display("mid-run reset test done");
        t_write();
        final_report();
    end
endmodule
